// *** logic/lrc_pkg.sv ***
// constants for the retry-limit, compare-swap and rom header register bank
// assumes a 32-bit register port with one-cycle strobes and one system clock
package lrc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int LIMIT_W = 4;
	localparam int UNIT_N = 3;
	localparam int SEL_W = 2;

	// register byte offsets
	localparam logic [7:0] OFS_RETRY = 8'h08;
	localparam logic [7:0] OFS_CS_DATA = 8'h0C;
	localparam logic [7:0] OFS_CS_COMPARE = 8'h10;
	localparam logic [7:0] OFS_CS_CONTROL = 8'h14;
	localparam logic [7:0] OFS_ROM_HEADER = 8'h18;
	localparam logic [7:0] OFS_BUS_ID = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
	localparam logic [7:0] OFS_LINK_CTRL = 8'h48;

	// retry register fields, units indexed request/response/physical
	localparam int RETRY_REQ_LSB = 0;
	localparam int RETRY_RSP_LSB = 4;
	localparam int RETRY_PHY_LSB = 8;
	localparam int RETRY_LIVE_W = 12;
	localparam logic [11:0] RETRY_RESET = 12'h000;

	// compare-swap control fields
	localparam int CS_DONE_BIT = 31;
	localparam logic [1:0] SEL_BUS_MANAGER = 2'h0;
	localparam logic [1:0] SEL_BANDWIDTH = 2'h1;
	localparam logic [1:0] SEL_CHAN_HI = 2'h2;
	localparam logic [1:0] SEL_CHAN_LO = 2'h3;

	// bus-management resource contents after reset
	localparam logic [31:0] RES_BUS_MANAGER_RESET = 32'h0000003F;
	localparam logic [31:0] RES_BANDWIDTH_RESET = 32'h00001333;
	localparam logic [31:0] RES_CHAN_HI_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] RES_CHAN_LO_RESET = 32'hFFFFFFFF;

	localparam logic [31:0] ROM_HEADER_RESET = 32'h00000000;
	localparam logic [31:0] BUS_ID_VALUE = 32'h31333934;
	localparam int LINK_ON_BIT = 17;

	// remote node view of the rom
	localparam logic [47:0] REMOTE_ROM_HEADER = 48'hFFFFF0000400;
	localparam logic [47:0] REMOTE_BUS_ID = 48'hFFFFF0000404;

	// interrupt status bits
	localparam int IRQ_CS_DONE = 0;
	localparam int IRQ_RETRY_FAIL = 1;
	localparam int IRQ_W = 2;
endpackage

// *** logic/lrc_resource_mem.sv ***
// four bus-management resource words with registered read data
// assumes one write or read per cycle from the compare-swap engine
module lrc_resource_mem #(
	parameter int WIDTH = 32
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst_n,
	input  wire logic [1:0]       i_addr,
	input  wire logic             i_wr,
	input  wire logic [WIDTH-1:0] i_wdata,
	output logic      [WIDTH-1:0] o_rdata
);
	logic [WIDTH-1:0] mem [4];

	if (WIDTH != 32) begin : g_check
		$error("resource words are one quadlet wide");
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem[0] <= lrc_pkg::RES_BUS_MANAGER_RESET;
			mem[1] <= lrc_pkg::RES_BANDWIDTH_RESET;
			mem[2] <= lrc_pkg::RES_CHAN_HI_RESET;
			mem[3] <= lrc_pkg::RES_CHAN_LO_RESET;
			o_rdata <= '0;
		end else begin
			if (i_wr) begin
				mem[i_addr] <= i_wdata;
			end
			o_rdata <= mem[i_addr];
		end
	end
endmodule

// *** logic/lrc_retry_unit.sv ***
// attempt counter for one transmit unit: resend on busy or data-error ack
// assumes one packet in flight per unit and one ack per attempt
module lrc_retry_unit #(
	parameter int LIMIT_W = 4
) (
	input  wire logic               i_mclk,
	input  wire logic               i_rst_n,
	input  wire logic [LIMIT_W-1:0] i_limit,
	input  wire logic               i_start,
	input  wire logic               i_ack_retry,
	input  wire logic               i_ack_done,
	output logic                    o_resend,
	output logic                    o_fail,
	output logic      [LIMIT_W-1:0] o_count
);
	logic can_retry;

	if (LIMIT_W < 1 || LIMIT_W > 8) begin : g_check
		$error("retry limit width out of range");
	end

	// limit is sampled per ack, so a new limit applies to the next ack
	assign can_retry = o_count < i_limit;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_count <= '0;
			o_resend <= 1'b0;
			o_fail <= 1'b0;
		end else begin
			o_resend <= i_ack_retry && can_retry;
			o_fail <= i_ack_retry && !can_retry;
			if (i_start || i_ack_done || (i_ack_retry && !can_retry)) begin
				o_count <= '0;
			end else if (i_ack_retry) begin
				o_count <= o_count + 1'b1;
			end
		end
	end
endmodule

// *** logic/lrc_regs.sv ***
// register bank: retry limits, compare-swap engine, rom header, bus id
// assumes software on a one-cycle strobe port and remote rom reads on a
// separate quadlet port; both answer in the cycle after the strobe
//
// Contract
// RULE1: request unit resends up to the request-retry limit on busy or error.
// RULE2: response unit resends up to the response-retry limit on busy/error.
// RULE3: physical unit resends up to the physical-retry limit on busy/error.
// RULE4: second-limit and cycle-limit fields read as zero.
// RULE5: retry register bits 15 to 12 read as zero.
// RULE6: data register holds the value swapped in when compare succeeds.
// RULE7: compare register holds the value checked against the resource.
// RULE8: done flag bit 31 sets when a compare-swap ends; one after reset.
// RULE9: every control register write clears the done flag; a write in the cycle a swap finishes leaves it set.
// RULE10: select codes 0..3 pick manager id, bandwidth, channels hi, lo.
// RULE11: control register bits 30 to 2 read as zero.
// RULE12: rom header appears to remote nodes at the rom's first quadlet.
// RULE13: software keeps header fields valid while link on is set.
// RULE14: info-length and crc-length reset to zero.
// RULE15: bus id is read-only constant, first bus-info-block quadlet.
// RULE16: control write starts compare-swap; old value returns in data.
module lrc_regs (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic [2:0]  i_tx_start,
	input  wire logic [2:0]  i_tx_ack_retry,
	input  wire logic [2:0]  i_tx_ack_done,
	output logic      [2:0]  o_tx_resend,
	output logic      [2:0]  o_tx_fail,
	input  wire logic        i_remote_rd,
	input  wire logic [47:0] i_remote_addr,
	output logic      [31:0] o_remote_rdata,
	output logic             o_remote_ack,
	output logic             o_remote_err,
	output logic             o_link_on,
	output logic             o_cs_busy,
	output logic             o_irq
);
	typedef enum logic [1:0] {
		CS_IDLE,
		CS_READ,
		CS_SWAP
	} lrc_cs_state_type;

	lrc_cs_state_type cs_state;
	lrc_cs_state_type next_cs_state;

	logic [11:0] retry_limits;
	logic [31:0] cs_data;
	logic [31:0] cs_compare;
	logic        cs_done;
	logic [1:0]  cs_select;
	logic [31:0] rom_header;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic [31:0] res_rdata;
	logic [3:0]  unit_count [3];

	wire wr_retry = i_wr && i_addr == lrc_pkg::OFS_RETRY;
	wire wr_data = i_wr && i_addr == lrc_pkg::OFS_CS_DATA;
	wire wr_compare = i_wr && i_addr == lrc_pkg::OFS_CS_COMPARE;
	wire wr_control = i_wr && i_addr == lrc_pkg::OFS_CS_CONTROL;
	wire wr_header = i_wr && i_addr == lrc_pkg::OFS_ROM_HEADER;
	wire wr_status = i_wr && i_addr == lrc_pkg::OFS_IRQ_STATUS;
	wire wr_mask = i_wr && i_addr == lrc_pkg::OFS_IRQ_MASK;
	wire wr_link = i_wr && i_addr == lrc_pkg::OFS_LINK_CTRL;

	wire cs_start = wr_control && cs_state == CS_IDLE;
	wire cs_match = res_rdata == cs_compare;
	wire cs_finish = cs_state == CS_SWAP;
	wire res_wr = cs_finish && cs_match;
	wire any_fail = |o_tx_fail;

	// reserved and dual-phase fields are simply never stored
	wire [31:0] retry_view = {20'h00000, retry_limits}; // RULE4 RULE5
	wire [31:0] control_view = {cs_done, 29'h00000000, cs_select}; // RULE11
	wire [1:0] irq_events = {any_fail, cs_finish};

	// one decode for the software read mux
	function automatic logic [31:0] read_mux(input logic [7:0] a,
		input logic [31:0] retry_v, input logic [31:0] ctrl_v,
		input logic [31:0] data_v, input logic [31:0] cmp_v,
		input logic [31:0] hdr_v, input logic [1:0] st,
		input logic [1:0] mk, input logic lk);
		logic [31:0] r;
		r = '0;
		unique case (a)
			lrc_pkg::OFS_RETRY: r = retry_v;
			lrc_pkg::OFS_CS_DATA: r = data_v;
			lrc_pkg::OFS_CS_COMPARE: r = cmp_v;
			lrc_pkg::OFS_CS_CONTROL: r = ctrl_v;
			lrc_pkg::OFS_ROM_HEADER: r = hdr_v;
			lrc_pkg::OFS_BUS_ID: r = lrc_pkg::BUS_ID_VALUE; // RULE15
			lrc_pkg::OFS_IRQ_STATUS: r = {30'h00000000, st};
			lrc_pkg::OFS_IRQ_MASK: r = {30'h00000000, mk};
			lrc_pkg::OFS_LINK_CTRL: r = {14'h0000, lk, 17'h00000};
			default: r = '0;
		endcase
		return r;
	endfunction

	wire [31:0] rd_value = read_mux(i_addr, retry_view, control_view,
		cs_data, cs_compare, rom_header, irq_status, irq_mask, o_link_on);

	// remote quadlet reads see the header and the constant id
	wire remote_hdr = i_remote_addr == lrc_pkg::REMOTE_ROM_HEADER;
	wire remote_id = i_remote_addr == lrc_pkg::REMOTE_BUS_ID;
	wire [31:0] remote_value = remote_hdr ? rom_header : // RULE12
		(remote_id ? lrc_pkg::BUS_ID_VALUE : 32'h00000000); // RULE15

	for (genvar u = 0; u < lrc_pkg::UNIT_N; u++) begin : g_unit
		lrc_retry_unit #(
			.LIMIT_W (lrc_pkg::LIMIT_W)
		) u_retry (
			.i_mclk      (i_mclk),
			.i_rst_n     (i_rst_n),
			.i_limit     (retry_limits[u*4 +: 4]), // RULE1 RULE2 RULE3
			.i_start     (i_tx_start[u]),
			.i_ack_retry (i_tx_ack_retry[u]),
			.i_ack_done  (i_tx_ack_done[u]),
			.o_resend    (o_tx_resend[u]),
			.o_fail      (o_tx_fail[u]),
			.o_count     (unit_count[u])
		);
	end

	lrc_resource_mem #(
		.WIDTH (lrc_pkg::DATA_W)
	) u_res (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_addr  (cs_select), // RULE10
		.i_wr    (res_wr),
		.i_wdata (cs_data), // RULE6
		.o_rdata (res_rdata)
	);

	always_comb begin
		next_cs_state = cs_state;
		unique case (cs_state)
			CS_IDLE: if (cs_start) next_cs_state = CS_READ; // RULE16
			CS_READ: next_cs_state = CS_SWAP;
			CS_SWAP: next_cs_state = CS_IDLE;
			default: next_cs_state = CS_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_state <= CS_IDLE;
		end else begin
			cs_state <= next_cs_state;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			retry_limits <= lrc_pkg::RETRY_RESET;
			rom_header <= lrc_pkg::ROM_HEADER_RESET; // RULE14
			o_link_on <= 1'b0;
			irq_mask <= '0;
		end else begin
			if (wr_retry) retry_limits <= i_wdata[11:0];
			if (wr_header) rom_header <= i_wdata;
			if (wr_link) o_link_on <= i_wdata[lrc_pkg::LINK_ON_BIT];
			if (wr_mask) irq_mask <= i_wdata[1:0];
		end
	end

	// old resource value replaces the data word when the swap ends
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_data <= '0;
			cs_compare <= '0;
		end else begin
			if (cs_finish) begin
				cs_data <= res_rdata; // RULE16
			end else if (wr_data) begin
				cs_data <= i_wdata;
			end
			if (wr_compare) cs_compare <= i_wdata; // RULE7
		end
	end

	// the finishing set wins over a clearing write in the same cycle
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_done <= 1'b1; // RULE8
			cs_select <= lrc_pkg::SEL_BUS_MANAGER;
		end else begin
			if (cs_finish) begin
				cs_done <= 1'b1; // RULE8
			end else if (wr_control) begin
				cs_done <= 1'b0; // RULE9
			end
			if (cs_start) cs_select <= i_wdata[1:0];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~(wr_status ? i_wdata[1:0] : 2'h0))
				| irq_events;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
			o_remote_rdata <= '0;
			o_remote_ack <= 1'b0;
			o_remote_err <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rd_value : 32'h00000000;
			o_remote_rdata <= i_remote_rd ? remote_value : 32'h00000000;
			o_remote_ack <= i_remote_rd;
			o_remote_err <= i_remote_rd && !remote_hdr && !remote_id;
		end
	end

	assign o_cs_busy = cs_state != CS_IDLE;
	assign o_irq = |(irq_status & irq_mask);

	// checks
	sequence s_cs_launch;
		wr_control && !o_cs_busy;
	endsequence
	sequence s_cs_complete;
		##2 cs_finish ##1 cs_done;
	endsequence

	property p_cs_sequence;
		@(posedge i_mclk) disable iff (!i_rst_n)
		s_cs_launch |-> ##1 !cs_done and s_cs_complete;
	endproperty
	a_cs_sequence: assert property (p_cs_sequence) // RULE16
		else $error("compare-swap did not finish three cycles after start");

	property p_done_clear;
		@(posedge i_mclk) disable iff (!i_rst_n)
		wr_control && !cs_finish |=> !cs_done;
	endproperty
	a_done_clear: assert property (p_done_clear) // RULE9
		else $error("control write left done set");

	property p_done_stays;
		@(posedge i_mclk) disable iff (!i_rst_n)
		cs_done && !wr_control |=> cs_done;
	endproperty
	a_done_stays: assert property (p_done_stays) // RULE8
		else $error("done flag dropped without a control write");

	property p_swap_write;
		@(posedge i_mclk) disable iff (!i_rst_n)
		cs_finish && cs_match |=> ##1 res_rdata == $past(cs_data, 2);
	endproperty
	a_swap_write: assert property (p_swap_write) // RULE6
		else $error("matching swap did not store the data word");

	property p_swap_keep;
		@(posedge i_mclk) disable iff (!i_rst_n)
		cs_finish && !cs_match |=> ##1 res_rdata == $past(res_rdata, 2);
	endproperty
	a_swap_keep: assert property (p_swap_keep) // RULE7
		else $error("mismatching swap changed the resource");

	property p_old_value;
		@(posedge i_mclk) disable iff (!i_rst_n)
		cs_finish |=> cs_data == $past(res_rdata);
	endproperty
	a_old_value: assert property (p_old_value) // RULE16
		else $error("old resource value not returned in data");

	property p_retry_zero;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_rd && i_addr == lrc_pkg::OFS_RETRY |=> o_rdata[31:12] == 20'h00000;
	endproperty
	a_retry_zero: assert property (p_retry_zero) // RULE4 RULE5
		else $error("retry register upper bits not zero");

	property p_control_zero;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_rd && i_addr == lrc_pkg::OFS_CS_CONTROL
			|=> o_rdata[30:2] == 29'h00000000;
	endproperty
	a_control_zero: assert property (p_control_zero) // RULE11
		else $error("control register reserved bits not zero");

	property p_bus_id;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_remote_rd && remote_id |=> o_remote_rdata == lrc_pkg::BUS_ID_VALUE;
	endproperty
	a_bus_id: assert property (p_bus_id) // RULE15
		else $error("remote bus id quadlet wrong");

	property p_remote_header;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_remote_rd && remote_hdr && !wr_header
			|=> o_remote_rdata == rom_header;
	endproperty
	a_remote_header: assert property (p_remote_header) // RULE12
		else $error("remote header quadlet differs from register");

	property p_request_limit;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_tx_ack_retry[0] && !i_tx_start[0] && unit_count[0] >= retry_limits[3:0]
			|=> o_tx_fail[0] && !o_tx_resend[0];
	endproperty
	a_request_limit: assert property (p_request_limit) // RULE1
		else $error("request unit resent past its limit");

	property p_response_resend;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_tx_ack_retry[1] && unit_count[1] < retry_limits[7:4]
			|=> o_tx_resend[1];
	endproperty
	a_response_resend: assert property (p_response_resend) // RULE2
		else $error("response unit failed to resend under its limit");

	property p_phys_resend;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_tx_ack_retry[2] && unit_count[2] < retry_limits[11:8]
			|=> o_tx_resend[2] && !o_tx_fail[2];
	endproperty
	a_phys_resend: assert property (p_phys_resend) // RULE3
		else $error("physical unit failed to resend under its limit");

	property p_response_limit;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_tx_ack_retry[1] && unit_count[1] >= retry_limits[7:4]
			|=> o_tx_fail[1] && !o_tx_resend[1];
	endproperty
	a_response_limit: assert property (p_response_limit) // RULE2
		else $error("response unit resent past its limit");

	property p_busy_select;
		@(posedge i_mclk) disable iff (!i_rst_n)
		wr_control && o_cs_busy |=> $stable(cs_select);
	endproperty
	a_busy_select: assert property (p_busy_select) // RULE10
		else $error("select changed during a compare-swap");

	property p_remote_miss;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_remote_rd && !remote_hdr && !remote_id
			|=> o_remote_err && o_remote_rdata == 32'h00000000;
	endproperty
	a_remote_miss: assert property (p_remote_miss) // RULE12
		else $error("unmapped remote read not refused");
endmodule

// *** test/lrc_remote_node.sv ***
// remote node: quadlet reads of the rom image and per-unit transmit acks
// assumes the bench calls its tasks from a process synchronous to i_mclk
module lrc_remote_node (
	input  wire logic        i_mclk,
	input  wire logic [31:0] i_remote_rdata,
	input  wire logic        i_remote_ack,
	input  wire logic        i_remote_err,
	input  wire logic [2:0]  i_tx_resend,
	input  wire logic [2:0]  i_tx_fail,
	output logic             o_remote_rd,
	output logic      [47:0] o_remote_addr,
	output logic      [2:0]  o_tx_start,
	output logic      [2:0]  o_tx_ack_retry,
	output logic      [2:0]  o_tx_ack_done
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_remote_rd = 1'b0;
		o_remote_addr = 48'h0;
		o_tx_start = 3'h0;
		o_tx_ack_retry = 3'h0;
		o_tx_ack_done = 3'h0;
	end
	// address is inverted once released so a stale value never matches
	task quad(input logic [47:0] a, output logic [31:0] d,
		output logic ak, output logic er);
		@(posedge i_mclk);
		o_remote_rd <= 1'b1;
		o_remote_addr <= a;
		@(posedge i_mclk);
		o_remote_rd <= 1'b0;
		o_remote_addr <= ~a;
		#1;
		d = i_remote_rdata;
		ak = i_remote_ack;
		er = i_remote_err;
	endtask
	// k: 0 new packet, 1 busy or data-error ack, 2 complete ack
	task tx(input int k, input int u, output logic rs, output logic fl);
		@(posedge i_mclk);
		case (k)
			0: o_tx_start[u] <= 1'b1;
			1: o_tx_ack_retry[u] <= 1'b1;
			default: o_tx_ack_done[u] <= 1'b1;
		endcase
		@(posedge i_mclk);
		o_tx_start <= 3'h0;
		o_tx_ack_retry <= 3'h0;
		o_tx_ack_done <= 3'h0;
		#1;
		rs = i_tx_resend[u];
		fl = i_tx_fail[u];
	endtask
endmodule

// *** test/lrc_regs_bench.sv ***
// self-checking bench: register model compared with the bank at every read
// assumes the remote node model supplies rom reads and transmit acks
module lrc_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk = 1'b0;
	logic        i_rst_n, i_wr, i_rd;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, o_remote_rdata;
	logic [2:0]  tx_start, tx_retry, tx_done, o_tx_resend, o_tx_fail;
	logic        remote_rd, o_remote_ack, o_remote_err;
	logic        o_link_on, o_cs_busy, o_irq;
	logic [47:0] remote_addr;
	int          err_total, checks;
	logic [31:0] res [4];
	logic [31:0] v, cm, dt, old;
	logic        rs, fl, ak, er;
	logic [31:0] rst_tab [7] = '{32'h0, 32'h0, 32'h0, 32'h80000000,
		32'h0, lrc_pkg::BUS_ID_VALUE, 32'h0};

	lrc_regs i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_tx_start(tx_start), .i_tx_ack_retry(tx_retry),
		.i_tx_ack_done(tx_done), .o_tx_resend(o_tx_resend),
		.o_tx_fail(o_tx_fail), .i_remote_rd(remote_rd),
		.i_remote_addr(remote_addr), .o_remote_rdata(o_remote_rdata),
		.o_remote_ack(o_remote_ack), .o_remote_err(o_remote_err),
		.o_link_on(o_link_on), .o_cs_busy(o_cs_busy), .o_irq(o_irq));

	lrc_remote_node i_node (.i_mclk(i_mclk), .i_remote_rdata(o_remote_rdata),
		.i_remote_ack(o_remote_ack), .i_remote_err(o_remote_err),
		.i_tx_resend(o_tx_resend), .i_tx_fail(o_tx_fail),
		.o_remote_rd(remote_rd), .o_remote_addr(remote_addr),
		.o_tx_start(tx_start), .o_tx_ack_retry(tx_retry),
		.o_tx_ack_done(tx_done));

	always #4 i_mclk = ~i_mclk;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// strobe stays up until the next access or idle: accesses run back to back
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		i_wr <= w;
		i_rd <= ~w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		acc(1'b0, a, 32'h0);
		#1;
		q = o_rdata;
	endtask
	task idle;
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		@(posedge i_mclk);
		#1;
	endtask

	initial begin
		i_rst_n = 1'b0;
		i_addr = 8'h0;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		err_total = 0;
		checks = 0;
		res = '{lrc_pkg::RES_BUS_MANAGER_RESET, lrc_pkg::RES_BANDWIDTH_RESET,
			lrc_pkg::RES_CHAN_HI_RESET, lrc_pkg::RES_CHAN_LO_RESET};
		v = $urandom(32'h5E636528);
		repeat (4) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		#1;
		// offsets 0x08 to 0x20; the last one is unmapped
		for (int i = 0; i < 7; i++) begin
			rd(8'h08 + 8'(4 * i), v);
			chk(v, rst_tab[i]);
		end
		acc(1'b1, lrc_pkg::OFS_BUS_ID, ~lrc_pkg::BUS_ID_VALUE);
		rd(lrc_pkg::OFS_BUS_ID, v);
		chk(v, lrc_pkg::BUS_ID_VALUE);
		v = $urandom;
		acc(1'b1, lrc_pkg::OFS_RETRY, v);
		rd(lrc_pkg::OFS_RETRY, cm);
		chk(cm, v & 32'h00000FFF);
		idle;
		for (int u = 0; u < 3; u++) begin
			i_node.tx(0, u, rs, fl);
			for (int k = 0; k <= v[4*u+:4]; k++) begin
				i_node.tx(1, u, rs, fl);
				chk({30'h0, rs, fl}, (k < v[4*u+:4]) ? 32'h2 : 32'h1);
			end
			i_node.tx(2, u, rs, fl);
		end
		// first pass misses, second matches, third shows the swapped value
		for (int i = 0; i < 12; i++) begin
			old = res[i%4];
			cm = (i / 4 == 1) ? old : $urandom;
			dt = $urandom;
			acc(1'b1, lrc_pkg::OFS_CS_COMPARE, cm);
			acc(1'b1, lrc_pkg::OFS_CS_DATA, dt);
			acc(1'b1, lrc_pkg::OFS_CS_CONTROL, ($urandom & 32'hFFFFFFFC) | (i % 4));
			rd(lrc_pkg::OFS_CS_CONTROL, v);
			chk(v, i % 4);
			chk({31'h0, o_cs_busy}, 32'h1);
			idle;
			for (int n = 0; n < 20 && o_cs_busy !== 1'b0; n++) begin
				@(posedge i_mclk);
				#1;
			end
			rd(lrc_pkg::OFS_CS_CONTROL, v);
			chk(v, 32'h80000000 | (i % 4));
			rd(lrc_pkg::OFS_CS_DATA, v);
			chk(v, old);
			rd(lrc_pkg::OFS_CS_COMPARE, v);
			chk(v, cm);
			idle;
			if (cm == old)
				res[i%4] = dt;
		end
		// a control write while busy leaves the running swap alone
		old = res[1];
		cm = $urandom;
		dt = $urandom;
		acc(1'b1, lrc_pkg::OFS_CS_COMPARE, cm);
		acc(1'b1, lrc_pkg::OFS_CS_DATA, dt);
		acc(1'b1, lrc_pkg::OFS_CS_CONTROL, 32'h1);
		acc(1'b1, lrc_pkg::OFS_CS_CONTROL, 32'h2);
		idle;
		rd(lrc_pkg::OFS_CS_CONTROL, v);
		chk(v, 32'h80000001);
		rd(lrc_pkg::OFS_CS_DATA, v);
		chk(v, old);
		idle;
		if (cm == old)
			res[1] = dt;
		rd(lrc_pkg::OFS_IRQ_STATUS, v);
		chk(v, 32'h3);
		acc(1'b1, lrc_pkg::OFS_IRQ_MASK, 32'h0);
		idle;
		chk({31'h0, o_irq}, 32'h0);
		acc(1'b1, lrc_pkg::OFS_IRQ_MASK, 32'h1);
		idle;
		chk({31'h0, o_irq}, 32'h1);
		acc(1'b1, lrc_pkg::OFS_IRQ_STATUS, 32'h1);
		idle;
		chk({31'h0, o_irq}, 32'h0);
		acc(1'b1, lrc_pkg::OFS_IRQ_MASK, 32'h3);
		idle;
		chk({31'h0, o_irq}, 32'h1);
		acc(1'b1, lrc_pkg::OFS_IRQ_STATUS, 32'h2);
		rd(lrc_pkg::OFS_IRQ_STATUS, v);
		chk(v, 32'h0);
		idle;
		chk({31'h0, o_irq}, 32'h0);
		// header is made valid before the link is switched on
		cm = $urandom;
		acc(1'b1, lrc_pkg::OFS_ROM_HEADER, cm);
		acc(1'b1, lrc_pkg::OFS_LINK_CTRL, 32'h1 << lrc_pkg::LINK_ON_BIT);
		rd(lrc_pkg::OFS_ROM_HEADER, v);
		chk(v, cm);
		idle;
		chk({31'h0, o_link_on}, 32'h1);
		i_node.quad(lrc_pkg::REMOTE_ROM_HEADER, v, ak, er);
		chk(v, cm);
		chk({ak, er}, 32'h2);
		i_node.quad(lrc_pkg::REMOTE_BUS_ID, v, ak, er);
		chk(v, lrc_pkg::BUS_ID_VALUE);
		chk({ak, er}, 32'h2);
		i_node.quad(lrc_pkg::REMOTE_ROM_HEADER + 48'h8, v, ak, er);
		chk(v, 32'h0);
		chk({ak, er}, 32'h3);
		end_of_test;
	end

	// the full sequence needs well under a third of this span
	initial begin
		#100000;
		err_total++;
		end_of_test;
	end
endmodule
